// ==== rtl/pmwc_top.sv ====
// Purpose: Power mode sequencer with wake source qualification
// Assumes: Core requests modes with a one-cycle strobe
// Notes:   Wake pins pass a two flip-flop synchroniser
`include "pmwc_map.svh"
`default_nettype none
module pmwc_top
    import pmwc_pkg::*;
(
    // Clock and reset
    input  wire logic                   I_CLOCK,
    input  wire logic                   I_RST_B,
    // Mode request from the core
    input  wire logic                   I_MODE_REQ,
    input  wire logic [`PMWC_MODE_W-1:0] I_MODE_SEL,
    // Configuration
    input  wire logic                   I_TWO_CELL,
    // Wake sources
    input  wire logic                   I_IRQ_PENDING,
    input  wire logic                   I_RESET_EVENT,
    input  wire logic                   I_RTC_WAKE,
    input  wire logic                   I_PORT_MATCH,
    input  wire logic                   I_CMP0_WAKE,
    input  wire logic                   I_RESET_PIN,
    // Core and clock control
    output logic                        O_CORE_HALT,
    output logic                        O_CORE_RESTART,
    output logic                        O_PREC_OSC_EN,
    output logic                        O_INT_OSC_EN,
    output logic                        O_SYSCLK_EN,
    output logic                        O_PERIPH_CLK_EN,
    output logic                        O_PERIPH_PWR_EN,
    output logic                        O_CORE_SUPPLY_EN,
    output logic                        O_RTC_OSC_EN,
    output logic                        O_WAKE,
    output logic [`PMWC_MODE_W-1:0]     O_MODE
);
    logic [4:0]     raw_wake;       // Asynchronous wake group
    logic [4:0]     sync_wake;      // Synchronised wake group
    logic           rtc_w;          // Clock wake
    logic           port_w;         // Port match wake
    logic           cmp_w;          // Comparator wake
    logic           pin_w;          // Reset pin wake
    logic           rst_w;          // Any reset event
    logic           ext_wake;       // Suspend wake set
    logic           sleep_wake;     // Sleep wake set
    pmwc_state_type state;          // Current state
    pmwc_state_type next_state;     // Next state
    logic [1:0]     cnt;            // Restore counter
    logic [1:0]     next_cnt;       // Next restore count
    logic [7:0]     outs;           // Registered enables
    logic [7:0]     next_outs;      // Next enables
    logic           wake;           // Wake pulse register
    logic           next_wake;      // Next wake pulse
    logic           restart;        // Restart pulse register
    logic           next_restart;   // Next restart pulse
    logic [`PMWC_MODE_W-1:0] mode;      // Reported mode
    logic [`PMWC_MODE_W-1:0] next_mode; // Next reported mode

    assign raw_wake = {I_RESET_EVENT, I_RTC_WAKE, I_PORT_MATCH, I_CMP0_WAKE, I_RESET_PIN};

    // Synchronise the pin-level wake sources
    pmwc_sync #(.WIDTH(5)) u_sync (
        .i_clock (I_CLOCK),
        .i_rst_b (I_RST_B),
        .i_async (raw_wake),
        .o_sync  (sync_wake)
    );

    // Split the synchronised group back into named sources
    assign {rst_w, rtc_w, port_w, cmp_w, pin_w} = sync_wake;
    // Wake sets per low power mode; sleep gates the comparator on supply type
    assign ext_wake   = rtc_w | port_w | cmp_w | pin_w;
    assign sleep_wake = rtc_w | port_w | (cmp_w & I_TWO_CELL) | pin_w;

    // Enables per state: halt,prec,int,sysclk,pclk,ppwr,supply,rtc
    function automatic logic [7:0] mode_outs(input pmwc_state_type s);
        case (s)
            PMWC_RUN:     mode_outs = `PMWC_EN_RUN;
            PMWC_IDLE:    mode_outs = `PMWC_EN_IDLE;
            PMWC_STOP:    mode_outs = `PMWC_EN_STOP;
            PMWC_SUSPEND: mode_outs = `PMWC_EN_SUSPEND;
            PMWC_SLEEP:   mode_outs = `PMWC_EN_SLEEP;
            PMWC_RESTORE: mode_outs = `PMWC_EN_RESTORE;
            default:      mode_outs = `PMWC_EN_RUN;
        endcase
    endfunction

    // Next state, counter, and outputs
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_wake    = 1'b0;
        next_restart = 1'b0;
        case (state)
            PMWC_RUN: begin
                if (I_MODE_REQ) begin
                    case (I_MODE_SEL)
                        `PMWC_REQ_IDLE:    next_state = PMWC_IDLE;
                        `PMWC_REQ_STOP:    next_state = PMWC_STOP;
                        `PMWC_REQ_SUSPEND: next_state = PMWC_SUSPEND;
                        `PMWC_REQ_SLEEP:   next_state = PMWC_SLEEP;
                        default:           next_state = PMWC_RUN;
                    endcase
                end
            end
            PMWC_IDLE: begin
                if (I_IRQ_PENDING) begin
                    next_state = PMWC_RESTORE;
                    next_cnt   = `PMWC_RESTORE_CNT;
                end
            end
            PMWC_STOP: begin
                if (rst_w) begin
                    next_state = PMWC_RESTORE;
                    next_cnt   = `PMWC_RESTORE_CNT;
                end
            end
            PMWC_SUSPEND: begin
                if (ext_wake) begin
                    next_state = PMWC_RESTORE;
                    next_cnt   = `PMWC_RESTORE_CNT;
                end
            end
            PMWC_SLEEP: begin
                if (sleep_wake) begin
                    next_state = PMWC_RESTORE;
                    next_cnt   = `PMWC_RESTORE_CNT;
                end
            end
            PMWC_RESTORE: begin
                // Hold the core while clocks and supply settle
                if (cnt == `PMWC_CNT_ONE) begin
                    next_state   = PMWC_RUN;
                    next_wake    = 1'b1;
                    next_restart = 1'b1;
                    next_cnt     = `PMWC_CNT_ZERO;
                end else begin
                    next_cnt = cnt - `PMWC_CNT_ONE;
                end
            end
            default: next_state = PMWC_RUN;
        endcase
        next_outs = mode_outs(next_state);
        case (next_state)
            PMWC_IDLE:    next_mode = `PMWC_REQ_IDLE;
            PMWC_STOP:    next_mode = `PMWC_REQ_STOP;
            PMWC_SUSPEND: next_mode = `PMWC_REQ_SUSPEND;
            PMWC_SLEEP:   next_mode = `PMWC_REQ_SLEEP;
            default:      next_mode = `PMWC_REQ_NORMAL;
        endcase
    end

    // Register state and outputs
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state   <= PMWC_RUN;
            cnt     <= `PMWC_CNT_ZERO;
            outs    <= `PMWC_EN_RUN;
            wake    <= 1'b0;
            restart <= 1'b0;
            mode    <= `PMWC_REQ_NORMAL;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            outs    <= next_outs;
            wake    <= next_wake;
            restart <= next_restart;
            mode    <= next_mode;
        end
    end

    assign O_CORE_HALT      = outs[7];
    assign O_PREC_OSC_EN    = outs[6];
    assign O_INT_OSC_EN     = outs[5];
    assign O_SYSCLK_EN      = outs[4];
    assign O_PERIPH_CLK_EN  = outs[3];
    assign O_PERIPH_PWR_EN  = outs[2];
    assign O_CORE_SUPPLY_EN = outs[1];
    assign O_RTC_OSC_EN     = outs[0];
    assign O_WAKE           = wake;
    assign O_CORE_RESTART   = restart;
    assign O_MODE           = mode;

    // Checks: enables follow the mode, wakes follow the allowed sources
    a_mode_entry: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (state == PMWC_RUN && I_MODE_REQ && I_MODE_SEL == `PMWC_REQ_SLEEP) |=> O_MODE == `PMWC_REQ_SLEEP)
        else $error("sleep request not entered");
    a_idle_periph: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (O_MODE == `PMWC_REQ_IDLE) |-> (O_CORE_HALT && O_PERIPH_CLK_EN && O_SYSCLK_EN))
        else $error("idle enables wrong");
    a_idle_wake: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (state == PMWC_IDLE && I_IRQ_PENDING) |=> ##2 O_WAKE)
        else $error("idle wake late");
    a_stop_osc: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (O_MODE == `PMWC_REQ_STOP) |-> (!O_PREC_OSC_EN && O_CORE_HALT))
        else $error("stop oscillator on");
    a_stop_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (state == PMWC_STOP && !rst_w) |=> state == PMWC_STOP)
        else $error("stop left without reset");
    a_susp_gate: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (O_MODE == `PMWC_REQ_SUSPEND) |-> (!O_SYSCLK_EN && !O_INT_OSC_EN && !O_PREC_OSC_EN))
        else $error("suspend clocks on");
    a_sleep_off: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (O_MODE == `PMWC_REQ_SLEEP) |-> (!O_CORE_SUPPLY_EN && O_RTC_OSC_EN))
        else $error("sleep supply on");
    a_sleep_cmp: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (state == PMWC_SLEEP && !I_TWO_CELL && !rtc_w && !port_w && !pin_w) |=> state == PMWC_SLEEP)
        else $error("comparator woke one-cell sleep");
    a_sleep_periph: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (O_MODE == `PMWC_REQ_SLEEP) |-> (!O_PERIPH_CLK_EN && !O_PERIPH_PWR_EN))
        else $error("peripherals alive in sleep");
    a_wake_restore: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        O_CORE_RESTART |-> (O_SYSCLK_EN && O_CORE_SUPPLY_EN && !O_CORE_HALT && O_MODE == `PMWC_REQ_NORMAL))
        else $error("restart before restore");
    // Restore holds two cycles before the wake pulse
    a_restore_len: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
        (state != PMWC_RESTORE) ##1 (state == PMWC_RESTORE) |-> ##2 O_WAKE)
        else $error("restore length wrong");
    // Scenario coverage: one wake out of each low power mode
    c_idle_wake:  cover property (@(posedge I_CLOCK) state == PMWC_IDLE ##1 state == PMWC_RESTORE);
    c_sleep_wake: cover property (@(posedge I_CLOCK) state == PMWC_SLEEP ##1 state == PMWC_RESTORE);
    c_susp_wake:  cover property (@(posedge I_CLOCK) state == PMWC_SUSPEND ##1 state == PMWC_RESTORE);
    c_stop_wake:  cover property (@(posedge I_CLOCK) state == PMWC_STOP ##1 state == PMWC_RESTORE);
endmodule
`default_nettype wire

// ==== pkg/pmwc_map.svh ====
// Purpose: Constants for the power mode wake controller
// Assumes: Included by the design files and the bench
// Notes:   Summary of operation follows
//
// Summary of operation
// - Five selectable modes: normal, idle, stop, suspend, sleep
// - Idle halts core; any enabled interrupt wakes
// - Stop kills precision oscillator; only reset wakes
// - Suspend stops precision and internal oscillators, gates clock; limited wakes
// - Sleep gates supply; only clock oscillator stays
// - Comparator wake in sleep needs two-cell supply
// - Sleep removes clock and power from peripherals
`ifndef PMWC_MAP_SVH
`define PMWC_MAP_SVH
`define PMWC_MODE_W      3
`define PMWC_REQ_NORMAL  3'h0
`define PMWC_REQ_IDLE    3'h1
`define PMWC_REQ_STOP    3'h2
`define PMWC_REQ_SUSPEND 3'h3
`define PMWC_REQ_SLEEP   3'h4
`define PMWC_RESTORE_CNT 2'h2
`define PMWC_CNT_ZERO    2'h0
`define PMWC_CNT_ONE     2'h1
// Halt and enable patterns: halt,prec,int,sysclk,pclk,ppwr,supply,rtc
`define PMWC_EN_RUN      8'h7f
`define PMWC_EN_IDLE     8'hff
`define PMWC_EN_STOP     8'hbf
`define PMWC_EN_SUSPEND  8'h87
`define PMWC_EN_SLEEP    8'h81
`define PMWC_EN_RESTORE  8'hff
`endif

// ==== pkg/pmwc_pkg.sv ====
// Purpose: Types for the power mode wake controller
// Assumes: Map header holds the numbers
// Notes:   State enumeration only
`default_nettype none
package pmwc_pkg;
    // Controller states
    typedef enum logic [2:0] {
        PMWC_RUN,
        PMWC_IDLE,
        PMWC_STOP,
        PMWC_SUSPEND,
        PMWC_SLEEP,
        PMWC_RESTORE
    } pmwc_state_type;
endpackage
`default_nettype wire

// ==== rtl/pmwc_sync.sv ====
// Purpose: Two flip-flop synchroniser for a group of level inputs
// Assumes: Inputs come from outside the clock domain
// Notes:   First stage is read only by the second
`include "pmwc_map.svh"
`default_nettype none
module pmwc_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;      // Metastability catcher
    logic [WIDTH-1:0] stage2;      // Stable copy
    logic [WIDTH-1:0] next_stage1; // Next first stage
    logic [WIDTH-1:0] next_stage2; // Next second stage

    // Next values of the chain
    always_comb begin
        next_stage1 = i_async;
        next_stage2 = stage1;
    end

    // Register the chain
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_sync = stage2;
endmodule
`default_nettype wire

// ==== dv/pmwc_core_model.sv ====
// Purpose: Core and wake source model for the power mode bench
// Assumes: Everything changes at the falling edge of the clock
// Notes:   Wake levels stay high until the bench clears them
`default_nettype none
module pmwc_core_model (
    // Clock
    input  wire logic i_clock,
    // Mode request from the core
    output logic       o_req,
    output logic [2:0] o_sel,
    // Wake levels: irq, reset event, rtc, port, cmp0, pin
    output logic [5:0] o_src
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet at time zero
    initial begin
        o_req = 1'b0;
        o_sel = 3'h0;
        o_src = 6'h0;
    end
    // One-cycle request strobe
    task automatic request(input logic [2:0] m);
        @(negedge i_clock);
        o_req = 1'b1;
        o_sel = m;
        @(negedge i_clock);
        o_req = 1'b0;
    endtask
    // Raise one wake level and hold it
    task automatic raise(input int s);
        @(negedge i_clock);
        o_src[s] = 1'b1;
    endtask
    // Release every wake level
    task automatic clear();
        @(negedge i_clock);
        o_src = 6'h0;
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the power mode controller
// Assumes: Model of modes, enables and wake sources
// Notes:   Inputs change at the falling edge
`include "pmwc_map.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;  // System clock
    logic       rst_b;       // Reset, active low
    logic       tc;          // Two-cell supply
    wire        req;         // Request strobe
    wire  [2:0] sel;         // Requested mode
    wire  [5:0] src;         // Wake levels
    wire  [7:0] en;          // Halt then enables
    wire        wk;          // Wake pulse
    wire        rs;          // Restart pulse
    logic [2:0] codes [4] = '{3'h0, 3'h5, 3'h6, 3'h7}; // Codes to ignore
    wire  [2:0] mode;        // Reported mode
    int         fails;       // Mismatches
    int         comparisons; // Checks made
    int         cycles;      // Timeout counter
    int         seed;        // Random seed
    // 50 MHz clock
    always #10 clk = ~clk;
    pmwc_core_model p (.i_clock(clk), .o_req(req), .o_sel(sel), .o_src(src));
    pmwc_top dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_MODE_REQ(req), .I_MODE_SEL(sel),
        .I_TWO_CELL(tc), .I_IRQ_PENDING(src[0]), .I_RESET_EVENT(src[1]), .I_RTC_WAKE(src[2]),
        .I_PORT_MATCH(src[3]), .I_CMP0_WAKE(src[4]), .I_RESET_PIN(src[5]), .O_CORE_HALT(en[7]),
        .O_CORE_RESTART(rs), .O_PREC_OSC_EN(en[6]), .O_INT_OSC_EN(en[5]), .O_SYSCLK_EN(en[4]),
        .O_PERIPH_CLK_EN(en[3]), .O_PERIPH_PWR_EN(en[2]), .O_CORE_SUPPLY_EN(en[1]),
        .O_RTC_OSC_EN(en[0]), .O_WAKE(wk), .O_MODE(mode));
    // Expected halt and enables per mode
    function automatic logic [7:0] pat(input int m);
        case (m)
            1: return 8'hff;
            2: return 8'hbf;
            3: return 8'h87;
            4: return 8'h81;
            default: return 8'h7f;
        endcase
    endfunction
    // Source that may wake mode m
    function automatic bit ok(input int m, input int s, input bit t);
        case (m)
            1: return s == 0;
            2: return s == 1;
            3: return s >= 2;
            default: return s >= 2 && (s != 4 || t);
        endcase
    endfunction
    // Source that mode m must ignore
    function automatic bit bad(input int m, input int s, input bit t);
        if (m == 2) return s != 1;
        return s == 0 || (m == 4 && s == 4 && !t);
    endfunction
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // Enter mode m and check the enables
    task automatic go(input int m);
        p.request(m[2:0]);
        check("mode", m[7:0], {5'h0, mode});
        check("enables", pat(m), en);
    endtask
    // Raise source s and expect a return to normal
    task automatic wake(input int s);
        int c;
        logic [7:0] last;
        c = 0;
        last = 8'h0;
        p.raise(s);
        while (wk !== 1'b1 && c < 8) begin
            last = en;
            @(posedge clk);
            #1;
            c++;
        end
        check("wake", 8'h1, {7'h0, wk});
        check("restart", 8'h1, {7'h0, rs});
        check("restore enables", 8'hff, last);
        check("run mode", 8'h0, {5'h0, mode});
        @(posedge clk);
        #1;
        check("pulse", 8'h0, {7'h0, wk});
        check("restart pulse", 8'h0, {7'h0, rs});
        p.clear();
        check("run enables", 8'h7f, en);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        rst_b = 1'b0;
        tc = 1'b1;
        seed = $urandom(32'hbcf9);
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check("reset", 8'h7f, en);
        $display("test reset done");
        // Unknown codes and normal leave the device running
        foreach (codes[i]) begin
            p.request(codes[i]);
            check("ignored", 8'h7f, en);
            check("ignored mode", 8'h0, {5'h0, mode});
        end
        $display("test codes done");
        // Every mode with every allowed source
        for (int m = 1; m <= 4; m++) begin
            for (int s = 0; s < 6; s++) begin
                if (ok(m, s, tc)) begin
                    go(m);
                    p.request(3'h4);
                    check("no nest", m[7:0], {5'h0, mode});
                    wake(s);
                end
            end
        end
        $display("test wake done");
        // Sources that must not wake
        for (int t = 0; t < 2; t++) begin
            tc = t[0];
            for (int m = 2; m <= 4; m++) begin
                for (int s = 0; s < 6; s++) begin
                    if (bad(m, s, tc)) begin
                        go(m);
                        p.raise(s);
                        repeat (8) @(negedge clk);
                        check("held", m[7:0], {5'h0, mode});
                        p.clear();
                        wake(m == 2 ? 1 : 2);
                    end
                end
            end
        end
        $display("test refuse done");
        // Random modes and sources
        repeat (20) begin
            int m;
            int s;
            m = 1 + $urandom % 4;
            tc = 1'($urandom % 2);
            do s = $urandom % 6; while (!ok(m, s, tc));
            go(m);
            wake(s);
        end
        $display("test random done");
        // Reset in the middle of sleep returns to normal at once
        go(4);
        @(negedge clk);
        rst_b = 1'b0;
        #1;
        check("mid reset enables", 8'h7f, en);
        check("mid reset mode", 8'h0, {5'h0, mode});
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        go(1);
        wake(0);
        $display("test mid reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
